// ### hw/hlfs_axis.sv
`timescale 1ns/10ps
`include "hlfs_cfg.svh"
// What this block does
// RULE1 - an axis that raises an alarm drives its hot-line alarm output to the controller.
// RULE2 - the controller answers any hot-line alarm by sending the forced stop to every axis.
// RULE3 - the forced stop must reach all axes before the faulted axis drops its link.
// RULE4 - a forced stop received in normal run latches the warning, shows E7.1 and starts a deceleration.
// RULE5 - when the link upstream dies the axis decelerates, reports no connection and shows AA.
// RULE6 - the function is on by default and a lowest config digit of 1 turns it off.
// RULE7 - the warning stays latched until the controller sends an error reset.
// RULE8 - supply loss during a forced-stop deceleration switches to the dynamic brake.
// RULE9 - a link break may engage the dynamic brake depending on how the link was shut off.
// RULE10 - outside brake circuits open when the malfunction or brake interlock output goes off.
// RULE11 - each axis takes the upstream port from the controller side and passes downstream; last is capped.
// RULE12 - after the brake interlock turns off the drive stage waits the configured delay before cutoff.
module hlfs_axis #(
   parameter int DELAY_W = 16,
   parameter int STEP_CYC = `HLFS_DELAY_STEP_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic alarm_in,
   input wire logic alarm_dyn_brake_in,
   input wire logic hot_line_stop_in,
   input wire logic error_reset_in,
   input wire logic link_up_in,
   input wire logic link_abrupt_in,
   input wire logic supply_ok_in,
   input wire logic motor_stopped_in,
   input wire logic [3:0] hot_line_config_param_in,
   input wire logic [DELAY_W-1:0] drive_cutoff_delay_param_in,
   output logic hot_line_alarm_out,
   output logic warning_latched_out,
   output logic link_lost_out,
   output hlfs_pkg::hlfs_drive_t drive_out,
   output hlfs_pkg::hlfs_disp_t disp_out
);
   import hlfs_pkg::*;

   // all outside levels come from other equipment, so two flops each
   localparam int NSYNC = 8;
   // supply reads good while the flops fill, so leaving reset is not taken for a power loss
   localparam logic [NSYNC-1:0] SYNC_IDLE = 8'h02;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   assign raw = {alarm_in, alarm_dyn_brake_in, hot_line_stop_in, error_reset_in,
                 link_up_in, link_abrupt_in, supply_ok_in, motor_stopped_in};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               meta_q[gi] <= SYNC_IDLE[gi];
               sync_q[gi] <= SYNC_IDLE[gi];
            end else begin
               meta_q[gi] <= raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   logic alarm_s, alarm_db_s, stop_s, reset_s, link_s, abrupt_s, supply_s, stopped_s;
   assign {alarm_s, alarm_db_s, stop_s, reset_s, link_s, abrupt_s, supply_s, stopped_s} = sync_q;

   logic func_en;
   logic reset_q;
   logic reset_rise;
   logic warn_q;
   logic lost_q;
   logic link_seen_q;
   logic warn_set;
   hlfs_state_t state_q;
   hlfs_state_t state_d;
   logic timer_start;
   logic timer_done;

   assign func_en = (hot_line_config_param_in != `HLFS_CFG_DISABLE_VAL); // [RULE6]
   assign reset_rise = reset_s && !reset_q;
   // stop while link still up and the axis itself is not faulted
   assign warn_set = func_en && stop_s && link_s && !alarm_s && !alarm_db_s; // [RULE4] [RULE3]

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reset_q <= 1'b0;
      end else begin
         reset_q <= reset_s;
      end
   end

   // alarm line mirrors the alarm; it is dropped when the function is off
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hot_line_alarm_out <= 1'b0;
      end else begin
         hot_line_alarm_out <= func_en && (alarm_s || alarm_db_s); // [RULE1] [RULE6]
      end
   end

   // a new forced stop in the reset cycle wins, so nothing is lost
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         warn_q <= 1'b0;
      end else if (warn_set) begin
         warn_q <= 1'b1; // [RULE4]
      end else if (reset_rise) begin
         warn_q <= 1'b0; // [RULE7]
      end
   end

   // link loss only counts once the link has been up since reset
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         link_seen_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         if (link_s) begin
            link_seen_q <= 1'b1;
         end
         lost_q <= link_seen_q && !link_s; // [RULE5]
      end
   end

   assign timer_start = (state_q == HLFS_DECEL) && (state_d == HLFS_BRAKE_WAIT);

   always_comb begin
      state_d = state_q;
      case (state_q)
         HLFS_RUN: begin
            if (alarm_db_s || (lost_q && abrupt_s) || !supply_s) begin
               state_d = HLFS_DYN_BRAKE; // [RULE9]
            end else if (warn_q || lost_q || alarm_s) begin
               state_d = HLFS_DECEL; // [RULE4] [RULE5]
            end
         end
         HLFS_DECEL: begin
            if (!supply_s || alarm_db_s || (lost_q && abrupt_s)) begin
               state_d = HLFS_DYN_BRAKE; // [RULE8] [RULE9]
            end else if (stopped_s) begin
               state_d = HLFS_BRAKE_WAIT;
            end
         end
         HLFS_BRAKE_WAIT: begin
            if (!supply_s) begin
               state_d = HLFS_DYN_BRAKE; // [RULE8]
            end else if (timer_done) begin
               state_d = HLFS_CUTOFF; // [RULE12]
            end
         end
         HLFS_CUTOFF, HLFS_DYN_BRAKE: begin
            if (supply_s && link_s && !warn_q && !alarm_s && !alarm_db_s) begin
               state_d = HLFS_RUN;
            end
         end
         default: state_d = HLFS_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= HLFS_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   hlfs_delay_timer #(
      .STEP_CYC(STEP_CYC),
      .DW(DELAY_W)
   ) u_cutoff_timer (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(timer_start),
      .steps_in(drive_cutoff_delay_param_in),
      .done_out(timer_done) // [RULE12]
   );

   // outputs from flops; interlock and malfunction low open outside brake contacts
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         drive_out <= '0;
      end else begin
         drive_out.malfunction_output <= !(alarm_s || alarm_db_s); // [RULE10]
         drive_out.brake_interlock_output <= (state_d == HLFS_RUN) || (state_d == HLFS_DECEL); // [RULE10]
         drive_out.drive_enable <= (state_d != HLFS_CUTOFF) && (state_d != HLFS_DYN_BRAKE); // [RULE12]
         drive_out.decel_request <= (state_d == HLFS_DECEL);
         drive_out.dyn_brake <= (state_d == HLFS_DYN_BRAKE); // [RULE8]
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         disp_out.code_hi <= `HLFS_DISP_NONE;
         disp_out.code_lo <= 8'h20;
         disp_out.show_dot <= 1'b0;
      end else if (lost_q) begin
         disp_out.code_hi <= `HLFS_DISP_NOLINK; // [RULE5]
         disp_out.code_lo <= 8'h20;
         disp_out.show_dot <= 1'b0;
      end else if (warn_q) begin
         disp_out.code_hi <= `HLFS_DISP_WARN_HI; // [RULE4]
         disp_out.code_lo <= `HLFS_DISP_WARN_LO;
         disp_out.show_dot <= 1'b1;
      end else begin
         disp_out.code_hi <= `HLFS_DISP_NONE;
         disp_out.code_lo <= 8'h20;
         disp_out.show_dot <= 1'b0;
      end
   end

   assign warning_latched_out = warn_q;
   assign link_lost_out = lost_q;
endmodule

// ### hw/hlfs_cfg.svh
`ifndef HLFS_CFG_SVH
`define HLFS_CFG_SVH
// lowest digit of the hot-line configuration value; 1 turns the function off
`define HLFS_CFG_DISABLE_VAL 4'h1
// display codes in 8-bit ascii; two characters each, one for the warning low part
`define HLFS_DISP_NONE 16'h2020
`define HLFS_DISP_WARN_HI 16'h4537
`define HLFS_DISP_WARN_LO 8'h31
`define HLFS_DISP_NOLINK 16'h4141
// one drive-cutoff delay step in ns (1 ms)
`define HLFS_DELAY_STEP_NS 1000000
`define HLFS_CLK_PERIOD_NS 5
`define HLFS_DELAY_STEP_CYC (`HLFS_DELAY_STEP_NS / `HLFS_CLK_PERIOD_NS)
`endif

// ### hw/hlfs_pkg.sv
package hlfs_pkg;
   typedef enum logic [2:0] {
      HLFS_RUN = 3'b000,
      HLFS_DECEL = 3'b001,
      HLFS_BRAKE_WAIT = 3'b010,
      HLFS_CUTOFF = 3'b011,
      HLFS_DYN_BRAKE = 3'b100
   } hlfs_state_t;

   typedef struct packed {
      logic malfunction_output;
      logic brake_interlock_output;
      logic drive_enable;
      logic decel_request;
      logic dyn_brake;
   } hlfs_drive_t;

   typedef struct packed {
      logic [15:0] code_hi;
      logic [7:0] code_lo;
      logic show_dot;
   } hlfs_disp_t;
endpackage

// ### hw/hlfs_delay_timer.sv
`timescale 1ns/10ps
`include "hlfs_cfg.svh"
// counts whole delay steps, each made from a one-cycle step enable
module hlfs_delay_timer #(
   parameter int STEP_CYC = `HLFS_DELAY_STEP_CYC,
   parameter int DW = 16
) (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire logic [DW-1:0] steps_in,
   output logic done_out
);
   logic [31:0] pre_q;
   logic [DW-1:0] cnt_q;
   logic run_q;
   logic step_en;

   assign step_en = run_q && (pre_q == 32'(STEP_CYC - 1));

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pre_q <= 32'h0;
      end else if (start_in || !run_q || step_en) begin
         pre_q <= 32'h0;
      end else begin
         pre_q <= pre_q + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_q <= 1'b0;
         cnt_q <= '0;
         done_out <= 1'b0;
      end else if (start_in) begin
         cnt_q <= steps_in;
         run_q <= (steps_in != '0);
         done_out <= (steps_in == '0);
      end else if (step_en) begin
         cnt_q <= cnt_q - DW'(1);
         if (cnt_q == DW'(1)) begin
            run_q <= 1'b0;
            done_out <= 1'b1;
         end
      end else begin
         done_out <= 1'b0;
      end
   end
endmodule

// ### tb/hlfs_axis_asserts.sv
`timescale 1ns/10ps
`include "hlfs_cfg.svh"
module hlfs_axis_asserts
   import hlfs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic alarm_in,
   input wire logic alarm_dyn_brake_in,
   input wire logic hot_line_stop_in,
   input wire logic error_reset_in,
   input wire logic link_up_in,
   input wire logic link_abrupt_in,
   input wire logic supply_ok_in,
   input wire logic [3:0] hot_line_config_param_in,
   input wire logic hot_line_alarm_out,
   input wire logic warning_latched_out,
   input wire logic link_lost_out,
   input wire hlfs_pkg::hlfs_drive_t drive_out,
   input wire hlfs_pkg::hlfs_disp_t disp_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_alarm;
      $rose(alarm_in) && hot_line_config_param_in != `HLFS_CFG_DISABLE_VAL |-> ##3 hot_line_alarm_out;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm not sent");
   property p_warn_set;
      $rose(hot_line_stop_in) && link_up_in && !alarm_in && !alarm_dyn_brake_in
         && hot_line_config_param_in != `HLFS_CFG_DISABLE_VAL
         |-> ##3 warning_latched_out;
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning not raised");
   property p_warn_show;
      $rose(warning_latched_out) |=> disp_out.code_hi == `HLFS_DISP_WARN_HI && disp_out.code_lo == `HLFS_DISP_WARN_LO
         && disp_out.show_dot && drive_out.decel_request;
   endproperty
   a_warn_show: assert property (p_warn_show) else $error("warning code or stop missing");
   property p_warn_hold;
      $fell(warning_latched_out) |-> $past(error_reset_in, 2) || $past(error_reset_in, 3);
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("warning cleared without reset");
   property p_link_lost;
      $fell(link_up_in) |-> ##3 link_lost_out ##[0:2] disp_out.code_hi == `HLFS_DISP_NOLINK;
   endproperty
   a_link_lost: assert property (p_link_lost) else $error("link loss not shown");
   property p_supply;
      $fell(supply_ok_in) && drive_out.decel_request |-> ##[2:5] drive_out.dyn_brake;
   endproperty
   a_supply: assert property (p_supply) else $error("no dynamic brake on supply loss");
   property p_abrupt;
      $fell(link_up_in) && link_abrupt_in |-> ##[2:5] drive_out.dyn_brake;
   endproperty
   a_abrupt: assert property (p_abrupt) else $error("no dynamic brake on abrupt link loss");
   property p_cutoff;
      $fell(drive_out.drive_enable) && !drive_out.dyn_brake |-> !$past(drive_out.brake_interlock_output);
   endproperty
   a_cutoff: assert property (p_cutoff) else $error("drive cut before brake interlock");
   property p_dyn_alarm;
      $rose(alarm_dyn_brake_in) && drive_out.brake_interlock_output
         |-> ##3 !drive_out.malfunction_output && drive_out.dyn_brake;
   endproperty
   a_dyn_alarm: assert property (p_dyn_alarm) else $error("dynamic brake alarm not handled");
endmodule
bind hlfs_axis hlfs_axis_asserts u_chk (.*);

// ### tb/hlfs_ctrl_model.sv
`timescale 1ns/10ps
// controller side; the stop follows the alarms, so only the axis latch can hold the warning
module hlfs_ctrl_model (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic hot_line_alarm_in,
   input wire logic other_alarm_in,
   input wire logic clear_in,
   input wire logic slow_in,
   input wire logic malfunction_in,
   input wire logic interlock_in,
   output logic brake_released_out,
   output logic hot_line_stop_out,
   output logic error_reset_out
);
   logic [3:0] wait_q;
   logic [2:0] pulse_q;
   assign error_reset_out = pulse_q != 3'h0;
   // outside brake contact: either output dropping opens it
   assign brake_released_out = malfunction_in && interlock_in;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_q <= 4'h0;
         hot_line_stop_out <= 1'b0;
      end else if (hot_line_alarm_in || other_alarm_in) begin
         // a slow answer still lands long before any link teardown
         wait_q <= wait_q + 4'h1;
         hot_line_stop_out <= hot_line_stop_out || !slow_in || wait_q == 4'h8;
      end else begin
         wait_q <= 4'h0;
         hot_line_stop_out <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         pulse_q <= 3'h0;
      else if (clear_in)
         pulse_q <= 3'h6;
      else if (pulse_q != 3'h0)
         pulse_q <= pulse_q - 3'h1;
   end
endmodule

// ### tb/hlfs_axis_bench.sv
`timescale 1ns/10ps
`include "hlfs_cfg.svh"
module hlfs_axis_bench;
   import hlfs_pkg::*;
   localparam int STEP = 4;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic alarm = 1'b0, abrupt = 1'b0, link_up = 1'b1, supply_ok = 1'b1, stopped = 1'b0;
   logic other = 1'b0, clear = 1'b0, slow = 1'b0, stop, err_rst, hl_alarm, warn, lost;
   logic dyn_alarm = 1'b0, brake_rel;
   logic [3:0] cfg = 4'h0;
   logic [15:0] dly = 16'h0;
   logic [31:0] seed = 32'hbb18;
   int fails = 0, check_count = 0, n;
   hlfs_drive_t drv;
   hlfs_disp_t disp;
   always #2.5 ref_clk = !ref_clk;
   hlfs_ctrl_model PARTNER (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .hot_line_alarm_in(hl_alarm),
      .other_alarm_in(other), .clear_in(clear), .slow_in(slow), .malfunction_in(drv.malfunction_output),
      .interlock_in(drv.brake_interlock_output), .brake_released_out(brake_rel),
      .hot_line_stop_out(stop), .error_reset_out(err_rst));
   hlfs_axis #(.STEP_CYC(STEP)) DUT (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .alarm_in(alarm),
      .alarm_dyn_brake_in(dyn_alarm), .hot_line_stop_in(stop), .error_reset_in(err_rst), .link_up_in(link_up),
      .link_abrupt_in(abrupt), .supply_ok_in(supply_ok), .motor_stopped_in(stopped),
      .hot_line_config_param_in(cfg), .drive_cutoff_delay_param_in(dly), .hot_line_alarm_out(hl_alarm),
      .warning_latched_out(warn), .link_lost_out(lost), .drive_out(drv), .disp_out(disp));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_warn(input logic [3:0] c);
      return c != `HLFS_CFG_DISABLE_VAL;
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic restart();
      reset_n <= 1'b0;
      {alarm, abrupt, stopped, other, clear, dyn_alarm} <= 6'h0;
      {link_up, supply_ok} <= 2'h3;
      cyc(2);
      reset_n <= 1'b1;
      cyc(1);
      #1;
      chk({drv, brake_rel}, 6'b111001);
      chk({disp.code_hi, disp.code_lo}, {`HLFS_DISP_NONE, 8'h20});
      cyc(4);
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #30000;
      fails++;
      conclude();
   end
   initial begin
      cyc(8);
      reset_n <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         restart();
         cfg <= (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : seed[7:4];
         dly <= {14'h0, seed[1:0]};
         slow <= seed[8];
         cyc(1);
         other <= 1'b1;
         cyc(20);
         #1;
         chk(warn, exp_warn(cfg));
         if (exp_warn(cfg)) begin
            chk({disp.code_hi, disp.code_lo}, {`HLFS_DISP_WARN_HI, `HLFS_DISP_WARN_LO});
            cyc(1);
            stopped <= 1'b1;
            for (n = 0; n < 20 && drv.brake_interlock_output !== 1'b0; n++) tick();
            chk(n < 6, 1'b1);
            for (n = 0; n < 30 && drv.drive_enable !== 1'b0; n++) tick();
            chk(n >= dly * STEP && n <= dly * STEP + 3, 1'b1);
         end
         cyc(1);
         other <= 1'b0;
         cyc(12);
         #1;
         chk(warn, exp_warn(cfg));
         cyc(1);
         clear <= 1'b1;
         cyc(1);
         clear <= 1'b0;
         cyc(12);
         #1;
         chk(warn, 1'b0);
      end
      restart();
      cfg <= 4'h0;
      cyc(1);
      alarm <= 1'b1;
      cyc(8);
      #1;
      chk(hl_alarm, 1'b1);
      chk(warn, 1'b0);
      for (int a = 0; a < 2; a++) begin
         restart();
         cyc(1);
         abrupt <= a[0];
         link_up <= 1'b0;
         cyc(7);
         #1;
         chk({lost, disp.code_hi}, {1'b1, `HLFS_DISP_NOLINK});
         chk(drv.dyn_brake, a[0]);
      end
      restart();
      cyc(1);
      other <= 1'b1;
      cyc(16);
      supply_ok <= 1'b0;
      cyc(6);
      #1;
      chk(drv.dyn_brake, 1'b1);
      restart();
      cyc(1);
      dyn_alarm <= 1'b1;
      cyc(6);
      #1;
      chk({drv.malfunction_output, drv.dyn_brake, brake_rel}, 3'b010);
      chk({hl_alarm, warn}, 2'b10);
      conclude();
   end
endmodule
